// file: hdl/gtc_top.sv
/*
 * Pin and trigger control: APB registers, three pins with trigger actions,
 * packet sequencing of 256 samples, pin 1 trigger output, packet tags and
 * a masked interrupt. Assumes sample_valid pulses once per converted sample.
 */
`timescale 1ns/1ps
module gtc_top
    import gtc_pkg::*;
(
    // Clock and reset
    input  wire logic        mclk,
    input  wire logic        rstn,
    input  wire logic        ce,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Pins
    input  wire logic [2:0]  gpio_i,
    output logic      [2:0]  gpio_o,
    output logic      [2:0]  gpio_oe,
    // Converter side
    input  wire logic        sample_valid,
    output logic             acq_run,
    output logic             pkt_start,
    output logic             pkt_done,
    output logic      [3:0]  sample_rate_value,
    output logic             filter_sel,
    output logic      [2:0]  vis_gain,
    output logic      [2:0]  ir_gain,
    // Packet tag
    output logic      [2:0]  tag_vis_gain,
    output logic      [2:0]  tag_ir_gain,
    output logic      [2:0]  tag_dir,
    output logic      [2:0]  tag_state,
    // Interrupt
    output logic             irq
);
    function automatic logic [2:0] gain_step(input logic [2:0] g, input logic up,
                                             input logic dn);
        logic [2:0] r;
        r = g;
        if (up && !dn && g != GAIN_MAX) begin
            r = g + 3'h1;
        end else if (dn && !up && g != 3'h0) begin
            r = g - 3'h1;
        end
        return r;
    endfunction

    function automatic logic [2:0] pin_hit(input logic [7:0] a);
        return {a == REG_PIN3_CFG, a == REG_PIN2_CFG, a == REG_PIN1_CFG};
    endfunction

    logic           ack;
    logic           wr_en;
    logic           rd_en;
    logic           mapped;
    logic [2:0]     pin_wr;
    logic [2:0]     pin_sel;
    logic [2:0]     dir;
    logic [2:0]     req_state;
    logic [2:0]     pol;
    gtc_action_type act [NUM_PINS];
    gtc_tmode_type  tmode;
    logic [2:0]     level;
    logic [2:0]     edge_hit;
    logic [2:0]     fired;
    logic [2:0]     drive;
    logic           toggle;
    logic [3:0]     pulse_cnt;
    logic [3:0]     irq_stat;
    logic [3:0]     irq_mask;
    gtc_acq_type    acq;
    logic [7:0]     cnt;
    logic           stop_pend;
    logic           do_shot;
    logic           do_start;
    logic           do_stop;
    logic           v_up;
    logic           v_dn;
    logic           i_up;
    logic           i_dn;
    logic           last_smp;
    logic           begin_pkt;
    logic [31:0]    next_rdata;

    // APB: one wait state, then pready with registered read data
    assign mapped  = (paddr[1:0] == 2'b00) && (paddr <= REG_PKT_TAG);
    assign pready  = ack;
    assign pslverr = ack & ~mapped;
    assign wr_en   = ce & psel & penable & ack & pwrite & mapped;
    assign rd_en   = ce & psel & penable & ack & ~pwrite & mapped;
    assign pin_sel = pin_hit(paddr);
    assign pin_wr  = wr_en ? pin_sel : 3'h0;

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            ack <= 1'b0;
        end else if (ce) begin
            ack <= psel & penable & ~ack;
        end
    end

    always_comb begin
        next_rdata = 32'h0;
        unique case (paddr)
            REG_CTRL: begin
                next_rdata[1:0] = acq;
            end
            REG_PIN1_CFG, REG_PIN2_CFG, REG_PIN3_CFG: begin
                for (int k = 0; k < NUM_PINS; k++) begin
                    if (pin_sel[k]) begin
                        next_rdata[PIN_DIR]                 = dir[k];
                        next_rdata[PIN_STATE]               = req_state[k];
                        next_rdata[PIN_ACT_LSB +: 3]        = act[k];
                        next_rdata[PIN_POL]                 = pol[k];
                        next_rdata[PIN_LEVEL]               = level[k];
                    end
                end
            end
            REG_TRIG_OUT: next_rdata[1:0] = tmode;
            REG_ACQ_CFG: begin
                next_rdata[3:0]      = sample_rate_value;
                next_rdata[ACQ_FILT] = filter_sel;
            end
            REG_GAIN: begin
                next_rdata[2:0]              = vis_gain;
                next_rdata[GAIN_IR_LSB +: 3] = ir_gain;
            end
            REG_IRQ_STAT: next_rdata[3:0] = irq_stat;
            REG_IRQ_MASK: next_rdata[3:0] = irq_mask;
            REG_PKT_TAG: begin
                next_rdata[2:0]                = tag_vis_gain;
                next_rdata[GAIN_IR_LSB +: 3]   = tag_ir_gain;
                next_rdata[TAG_DIR_LSB +: 3]   = tag_dir;
                next_rdata[TAG_STATE_LSB +: 3] = tag_state;
            end
            default: next_rdata = 32'h0;
        endcase
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            prdata <= 32'h0;
        end else if (ce && psel && penable && !ack) begin
            prdata <= next_rdata;
        end
    end

    // Pin configuration, one register per pin index
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            dir       <= DIR_RST;
            req_state <= 3'h0;
            pol       <= POL_RST;
            for (int k = 0; k < NUM_PINS; k++) begin
                act[k] <= ACT_NONE;
            end
        end else if (ce) begin
            for (int k = 0; k < NUM_PINS; k++) begin
                if (pin_wr[k]) begin
                    act[k] <= gtc_action_type'(pwdata[PIN_ACT_LSB +: 3]);
                    pol[k] <= pwdata[PIN_POL];
                    if (pwdata[PIN_ACT_LSB +: 3] != ACT_NONE) begin
                        dir[k] <= 1'b0;
                    end else if (k == 0 && tmode != TMODE_OFF) begin
                        dir[k] <= 1'b1;
                    end else begin
                        dir[k] <= pwdata[PIN_DIR];
                    end
                    if (dir[k]) begin
                        req_state[k] <= pwdata[PIN_STATE];
                    end
                end
            end
            if (wr_en && paddr == REG_TRIG_OUT && pwdata[1:0] != TMODE_OFF
                && pwdata[1:0] <= TMODE_MAX) begin
                dir[0] <= 1'b1;
                act[0] <= ACT_NONE;
            end
        end
    end

    // Output trigger mode, pin 1 only
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            tmode <= TMODE_OFF;
        end else if (ce) begin
            if (wr_en && paddr == REG_TRIG_OUT && pwdata[1:0] <= TMODE_MAX) begin
                tmode <= gtc_tmode_type'(pwdata[1:0]);
            end else if (pin_wr[0] && pwdata[PIN_ACT_LSB +: 3] != ACT_NONE) begin
                tmode <= TMODE_OFF;
            end
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < NUM_PINS; gi++) begin : g_pin
            gtc_edge_detect u_edge (
                .mclk     (mclk),
                .rstn     (rstn),
                .ce       (ce),
                .pin_i    (gpio_i[gi]),
                .pol      (pol[gi]),
                .level    (level[gi]),
                .edge_hit (edge_hit[gi])
            );
            assign fired[gi] = edge_hit[gi] & ~dir[gi] & (act[gi] != ACT_NONE);
        end
    endgenerate

    // Trigger actions merged with software commands
    always_comb begin
        do_shot  = wr_en && paddr == REG_CTRL && pwdata[CTRL_SHOT];
        do_start = wr_en && paddr == REG_CTRL && pwdata[CTRL_START];
        do_stop  = wr_en && paddr == REG_CTRL && pwdata[CTRL_STOP];
        v_up     = 1'b0;
        v_dn     = 1'b0;
        i_up     = 1'b0;
        i_dn     = 1'b0;
        for (int k = 0; k < NUM_PINS; k++) begin
            if (fired[k]) begin
                unique case (act[k])
                    ACT_NONE:  ;
                    ACT_SHOT:  do_shot  = 1'b1;
                    ACT_START: do_start = 1'b1;
                    ACT_STOP:  do_stop  = 1'b1;
                    ACT_VUP:   v_up     = 1'b1;
                    ACT_VDN:   v_dn     = 1'b1;
                    ACT_IUP:   i_up     = 1'b1;
                    ACT_IDN:   i_dn     = 1'b1;
                endcase
            end
        end
    end

    // Settings: rate, filter, gains
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            sample_rate_value <= RATE_RST;
            filter_sel        <= 1'b0;
            vis_gain          <= GAIN_RST;
            ir_gain           <= GAIN_RST;
        end else if (ce) begin
            if (wr_en && paddr == REG_ACQ_CFG) begin
                if (pwdata[3:0] <= RATE_MAX) begin
                    sample_rate_value <= pwdata[3:0];
                end
                filter_sel <= pwdata[ACQ_FILT];
            end
            if (wr_en && paddr == REG_GAIN) begin
                vis_gain <= pwdata[2:0];
                ir_gain  <= pwdata[GAIN_IR_LSB +: 3];
            end else begin
                vis_gain <= gain_step(vis_gain, v_up, v_dn);
                ir_gain  <= gain_step(ir_gain, i_up, i_dn);
            end
        end
    end

    // Packet sequencer
    assign last_smp  = acq_run & sample_valid & (cnt == PKT_LAST);
    assign begin_pkt = (acq == ACQ_IDLE && (do_start || do_shot))
                       || (acq == ACQ_CONT && last_smp && !stop_pend && !do_stop);
    assign acq_run   = acq != ACQ_IDLE;

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            acq       <= ACQ_IDLE;
            cnt       <= 8'h0;
            stop_pend <= 1'b0;
        end else if (ce) begin
            if (begin_pkt) begin
                cnt <= 8'h0;
            end else if (acq_run && sample_valid) begin
                cnt <= cnt + 8'h1;
            end
            unique case (acq)
                ACQ_IDLE: begin
                    stop_pend <= 1'b0;
                    if (do_start) begin
                        acq <= ACQ_CONT;
                    end else if (do_shot) begin
                        acq <= ACQ_SHOT;
                    end
                end
                ACQ_SHOT: begin
                    if (do_start) begin
                        acq <= ACQ_CONT;
                    end else if (last_smp) begin
                        acq <= ACQ_IDLE;
                    end
                end
                ACQ_CONT: begin
                    if (last_smp && (stop_pend || do_stop)) begin
                        acq <= ACQ_IDLE;
                    end else if (do_stop) begin
                        stop_pend <= 1'b1;
                    end
                end
                default: acq <= ACQ_IDLE;
            endcase
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            pkt_start <= 1'b0;
            pkt_done  <= 1'b0;
        end else if (ce) begin
            pkt_start <= begin_pkt;
            pkt_done  <= last_smp;
        end
    end

    // Pin drive updates only at packet start; the pin 1 pulse count then runs down each cycle
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            drive     <= 3'h0;
            toggle    <= 1'b0;
            pulse_cnt <= 4'h0;
        end else if (ce) begin
            if (begin_pkt) begin
                drive <= req_state;
                if (tmode == TMODE_TOGGLE) begin
                    toggle <= ~toggle;
                end
                if (tmode == TMODE_PULSE) begin
                    pulse_cnt <= PULSE_CYC;
                end
            end else if (pulse_cnt != 4'h0) begin
                pulse_cnt <= pulse_cnt - 4'h1;
            end
        end
    end

    always_comb begin
        gpio_oe = dir;
        gpio_o  = drive & dir;
        unique case (tmode)
            TMODE_PULSE:  gpio_o[0] = pulse_cnt != 4'h0;
            TMODE_TOGGLE: gpio_o[0] = toggle;
            default:      gpio_o[0] = drive[0] & dir[0];
        endcase
    end

    // Packet tag latched at packet start
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            tag_vis_gain <= 3'h0;
            tag_ir_gain  <= 3'h0;
            tag_dir      <= 3'h0;
            tag_state    <= 3'h0;
        end else if (ce && pkt_start) begin
            tag_vis_gain <= vis_gain;
            tag_ir_gain  <= ir_gain;
            tag_dir      <= dir;
            tag_state    <= gpio_o;
        end
    end

    // Interrupts: sticky, read clears, a new event wins
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            irq_stat <= 4'h0;
            irq_mask <= 4'h0;
        end else if (ce) begin
            if (wr_en && paddr == REG_IRQ_MASK) begin
                irq_mask <= pwdata[3:0];
            end
            irq_stat <= ((rd_en && paddr == REG_IRQ_STAT) ? 4'h0 : irq_stat)
                        | {fired, last_smp};
        end
    end

    assign irq = |(irq_stat & irq_mask);

    property p_state_ignored;
        @(posedge mclk) disable iff (!rstn)
        (pin_wr[1] && !dir[1]) |=> $stable(req_state[1]);
    endproperty
    a_state_ignored: assert property (p_state_ignored) else $error("state write on input");

    property p_act_input;
        @(posedge mclk) disable iff (!rstn)
        (pin_wr[2] && pwdata[PIN_ACT_LSB +: 3] != 3'h0) |=> !dir[2] && act[2] != ACT_NONE;
    endproperty
    a_act_input: assert property (p_act_input) else $error("action pin not input");

    property p_tmode_dir;
        @(posedge mclk) disable iff (!rstn)
        tmode != TMODE_OFF |-> dir[0] && gpio_oe[0];
    endproperty
    a_tmode_dir: assert property (p_tmode_dir) else $error("pin 1 not output");

    property p_out_per_pkt;
        @(posedge mclk) disable iff (!rstn)
        (ce && !begin_pkt) |=> $stable(gpio_o[2:1]) || $changed(dir[2:1]);
    endproperty
    a_out_per_pkt: assert property (p_out_per_pkt) else $error("pin changed mid packet");

    property p_toggle;
        @(posedge mclk) disable iff (!rstn)
        (ce && begin_pkt && tmode == TMODE_TOGGLE) |=> gpio_o[0] != $past(gpio_o[0]);
    endproperty
    a_toggle: assert property (p_toggle) else $error("no toggle at packet");

    property p_pulse;
        @(posedge mclk) disable iff (!rstn)
        (ce && begin_pkt && tmode == TMODE_PULSE) |=> gpio_o[0] [*2];
    endproperty
    a_pulse: assert property (p_pulse) else $error("pulse missing");

    property p_shot_end;
        @(posedge mclk) disable iff (!rstn)
        (ce && acq == ACQ_SHOT && last_smp && !do_start) |=> acq == ACQ_IDLE && pkt_done;
    endproperty
    a_shot_end: assert property (p_shot_end) else $error("shot did not end");

    property p_rate;
        @(posedge mclk) disable iff (!rstn)
        sample_rate_value <= RATE_MAX;
    endproperty
    a_rate: assert property (p_rate) else $error("rate code out of range");

    property p_gain_sat;
        @(posedge mclk) disable iff (!rstn)
        (ce && vis_gain == GAIN_MAX && v_up && !(wr_en && paddr == REG_GAIN)) |=>
            vis_gain == GAIN_MAX;
    endproperty
    a_gain_sat: assert property (p_gain_sat) else $error("gain wrapped");

    property p_tag;
        @(posedge mclk) disable iff (!rstn)
        (ce && pkt_start) |=> tag_vis_gain == $past(vis_gain) && tag_dir == $past(dir);
    endproperty
    a_tag: assert property (p_tag) else $error("tag not latched");

    c_shot:   cover property (@(posedge mclk) acq == ACQ_SHOT ##1 acq == ACQ_IDLE);
    c_cont:   cover property (@(posedge mclk) pkt_done && acq == ACQ_CONT);
    c_toggle: cover property (@(posedge mclk) tmode == TMODE_TOGGLE && pkt_start);
    c_trig:   cover property (@(posedge mclk) |fired);
endmodule

// file: shared/gtc_pkg.sv
/*
 * Package of the trigger and pin control block: register offsets, field
 * positions, reset values, action and mode codes, timing counts.
 * Assumes a 10 MHz mclk and a 32-bit APB register bus.
 */
package gtc_pkg;
    localparam int          NUM_PINS      = 3;
    // Register byte offsets
    localparam logic [7:0]  REG_CTRL      = 8'h00;
    localparam logic [7:0]  REG_PIN1_CFG  = 8'h04;
    localparam logic [7:0]  REG_PIN2_CFG  = 8'h08;
    localparam logic [7:0]  REG_PIN3_CFG  = 8'h0c;
    localparam logic [7:0]  REG_TRIG_OUT  = 8'h10;
    localparam logic [7:0]  REG_ACQ_CFG   = 8'h14;
    localparam logic [7:0]  REG_GAIN      = 8'h18;
    localparam logic [7:0]  REG_IRQ_STAT  = 8'h1c;
    localparam logic [7:0]  REG_IRQ_MASK  = 8'h20;
    localparam logic [7:0]  REG_PKT_TAG   = 8'h24;
    // Control fields
    localparam int          CTRL_SHOT     = 0;
    localparam int          CTRL_START    = 1;
    localparam int          CTRL_STOP     = 2;
    // Pin configuration fields
    localparam int          PIN_DIR       = 0;
    localparam int          PIN_STATE     = 1;
    localparam int          PIN_ACT_LSB   = 4;
    localparam int          PIN_POL       = 8;
    localparam int          PIN_LEVEL     = 9;
    // Acquisition, gain and packet tag fields
    localparam int          ACQ_FILT      = 4;
    localparam int          GAIN_IR_LSB   = 8;
    localparam int          TAG_DIR_LSB   = 16;
    localparam int          TAG_STATE_LSB = 20;
    // Interrupt status bits
    localparam int          IRQ_PKT       = 0;
    localparam int          IRQ_EDGE_LSB  = 1;
    // Codes and limits
    localparam logic [3:0]  RATE_MAX      = 4'ha;
    localparam logic [2:0]  GAIN_MAX      = 3'h7;
    localparam logic [7:0]  PKT_LAST      = 8'hff;
    localparam logic [1:0]  TMODE_MAX     = 2'h2;
    // Reset values
    localparam logic [2:0]  DIR_RST       = 3'h0;
    localparam logic [2:0]  POL_RST       = 3'h7;
    localparam logic [3:0]  RATE_RST      = 4'h0;
    localparam logic [2:0]  GAIN_RST      = 3'h0;
    // Trigger output pulse width
    localparam int          CLK_PERIOD_NS = 100;
    localparam int          PULSE_NS      = 1000;
    localparam logic [3:0]  PULSE_CYC     = 4'((PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

    typedef enum logic [2:0] {
        ACT_NONE  = 3'b000,
        ACT_SHOT  = 3'b001,
        ACT_START = 3'b010,
        ACT_STOP  = 3'b011,
        ACT_VUP   = 3'b100,
        ACT_VDN   = 3'b101,
        ACT_IUP   = 3'b110,
        ACT_IDN   = 3'b111
    } gtc_action_type;

    typedef enum logic [1:0] {
        TMODE_OFF    = 2'b00,
        TMODE_PULSE  = 2'b01,
        TMODE_TOGGLE = 2'b10
    } gtc_tmode_type;

    typedef enum logic [1:0] {
        ACQ_IDLE = 2'b00,
        ACQ_SHOT = 2'b01,
        ACQ_CONT = 2'b10
    } gtc_acq_type;
endpackage

// file: hdl/gtc_edge_detect.sv
/*
 * One trigger pin: two-flop synchroniser, then edge detection on the
 * selected polarity. Assumes pin input may change at any time.
 */
`timescale 1ns/1ps
module gtc_edge_detect
    import gtc_pkg::*;
(
    // Clock and reset
    input  wire logic mclk,
    input  wire logic rstn,
    input  wire logic ce,
    // Pin and setting
    input  wire logic pin_i,
    input  wire logic pol,
    // Results
    output logic      level,
    output logic      edge_hit
);
    logic meta;
    logic sync;
    logic prev;

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            meta <= 1'b0;
            sync <= 1'b0;
            prev <= 1'b0;
        end else if (ce) begin
            meta <= pin_i;
            sync <= meta;
            prev <= sync;
        end
    end

    assign level    = sync;
    // Rising when pol is 1, falling when 0
    assign edge_hit = ce & (sync != prev) & (sync == pol);

    property p_edge_once;
        @(posedge mclk) disable iff (!rstn)
        edge_hit |=> !edge_hit;
    endproperty
    a_edge_once: assert property (p_edge_once) else $error("edge reported twice");

    property p_edge_pol;
        @(posedge mclk) disable iff (!rstn)
        edge_hit |-> (level == pol) && (prev != pol);
    endproperty
    a_edge_pol: assert property (p_edge_pol) else $error("edge of wrong polarity");
endmodule

// file: tb/gtc_far_model.sv
/* Far side model: converter sample strobe and external trigger pins.
   Assumes the bench requests pin levels; the gap input sets sample pacing. */
`timescale 1ns/1ps
module gtc_far_model (
    // Clock and reset
    input  wire logic       mclk,
    input  wire logic       rstn,
    // Control
    input  wire logic       acq_run,
    input  wire logic [3:0] gap,
    input  wire logic [2:0] pin_req,
    // Outputs
    output logic            sample_valid,
    output logic      [2:0] gpio_i
);
    logic [3:0] cnt;
    assign gpio_i = pin_req;
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            cnt <= 4'h0;
            sample_valid <= 1'b0;
        end else begin
            cnt <= (cnt >= gap) ? 4'h0 : cnt + 4'h1;
            sample_valid <= acq_run && (cnt == 4'h0);
        end
    end
endmodule

// file: tb/tb_gtc_top.sv
/* Bench of the pin and trigger block: APB master, packet and trigger tests.
   Assumes one wait state per APB access and a far model pacing samples. */
`timescale 1ns/1ps
module tb_gtc_top;
    import gtc_pkg::*;
    logic        mclk, rstn, psel, penable, pwrite, pready, pslverr, sv, run, ps, pd;
    logic        filt, irq;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [2:0]  gi, go, goe, pin_req, vg, ig, tv, ti, td, ts;
    logic [3:0]  rate, code;
    int          mismatches, n_checks, seed, m_vis, npd, n;
    gtc_top gtc_top_inst (.mclk(mclk), .rstn(rstn), .ce(1'b1), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .gpio_i(gi), .gpio_o(go), .gpio_oe(goe), .sample_valid(sv),
        .acq_run(run), .pkt_start(ps), .pkt_done(pd), .sample_rate_value(rate),
        .filter_sel(filt), .vis_gain(vg), .ir_gain(ig), .tag_vis_gain(tv), .tag_ir_gain(ti),
        .tag_dir(td), .tag_state(ts), .irq(irq));
    gtc_far_model gtc_far_model_inst (.mclk(mclk), .rstn(rstn), .acq_run(run), .gap(4'h2),
        .pin_req(pin_req), .sample_valid(sv), .gpio_i(gi));
    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end
    task automatic summarize();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        n_checks++;
        if (s !== e) begin
            mismatches++;
            $display("ERROR %0t: got %h expected %h", $time, s, e);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        @(posedge mclk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge mclk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge mclk);
            k++;
        end while (pready !== 1'b1 && k < 50);
        rd = pslverr ? 32'hdead : prdata;
        if (k >= 50) begin
            mismatches++;
            summarize();
        end
        {psel, penable} <= 2'b00;
        @(negedge mclk);
    endtask
    task automatic pulse(input int p);
        @(posedge mclk);
        pin_req[p] <= 1'b1;
        repeat (6) @(posedge mclk);
        pin_req[p] <= 1'b0;
        repeat (6) @(posedge mclk);
        @(negedge mclk);
    endtask
    task automatic waitp(input int want);
        n = 0;
        while (n < 3000 && npd < want) begin
            @(negedge mclk);
            npd += pd;
            n++;
        end
        if (npd < want) begin
            mismatches++;
            summarize();
        end
    endtask
    initial begin
        {rstn, psel, penable, pwrite, paddr, pwdata, pin_req} = '0;
        seed = 75670;
        repeat (6) @(posedge mclk);
        rstn <= 1'b1;
        apb(0, REG_PIN1_CFG, 0);
        chk(rd, 32'h100);
        apb(1, REG_PIN2_CFG, 32'h102);
        apb(0, REG_PIN2_CFG, 0);
        chk(rd[1], 0);
        apb(1, REG_PIN2_CFG, 32'h103);
        chk(goe, 3'h2);
        apb(1, REG_PIN2_CFG, 32'h103);
        chk(go, 3'h0);
        code = 4'(($random(seed) & 32'hffff) % 11);
        apb(1, REG_ACQ_CFG, {27'h0, 1'b1, code});
        chk({filt, rate}, {1'b1, code});
        apb(1, REG_ACQ_CFG, 32'h0f);
        chk(rate, code);
        $display("settings done");
        apb(1, REG_IRQ_MASK, 1);
        apb(1, REG_CTRL, 1);
        chk({ps, run}, 2'b11);
        npd = 0;
        waitp(1);
        chk(run, 0);
        chk(go, 3'h2);
        chk({td, ts, tv}, {3'h2, 3'h2, 3'h0});
        apb(0, REG_PKT_TAG, 0);
        chk(rd, 32'h220000);
        chk(irq, 1);
        apb(0, REG_IRQ_STAT, 0);
        chk({rd[0], irq}, 2'b10);
        $display("packet done");
        apb(1, REG_PIN3_CFG, 32'h141);
        apb(0, REG_PIN3_CFG, 0);
        chk(rd[0], 0);
        m_vis = 0;
        for (int i = 0; i < 9; i++) begin
            pulse(2);
            m_vis = (m_vis < 7) ? m_vis + 1 : 7;
            chk(vg, m_vis);
        end
        apb(0, REG_IRQ_STAT, 0);
        chk(rd[3:0], 4'h8);
        apb(1, REG_PIN3_CFG, 32'h050);
        @(posedge mclk);
        pin_req[2] <= 1'b1;
        repeat (6) @(negedge mclk);
        chk(vg, m_vis);
        pulse(2);
        chk(vg, m_vis - 1);
        $display("trigger done");
        apb(1, REG_TRIG_OUT, 2);
        chk(goe[0], 1);
        apb(1, REG_TRIG_OUT, 3);
        apb(0, REG_TRIG_OUT, 0);
        chk(rd[1:0], 2);
        apb(1, REG_GAIN, 32'h503);
        apb(1, REG_PIN3_CFG, 32'h120);
        pulse(2);
        chk({run, go[0], ts[0]}, 3'h7);
        chk({ti, tv, ig}, 9'h15d);
        npd = 0;
        waitp(1);
        chk({run, go[0]}, 2'b10);
        apb(1, REG_CTRL, 4);
        waitp(2);
        chk({run, go[0]}, 2'b00);
        apb(1, REG_TRIG_OUT, 1);
        apb(1, REG_CTRL, 1);
        chk(go[0], 1);
        repeat (PULSE_CYC) @(negedge mclk);
        chk(go[0], 0);
        $display("sequence done");
        apb(0, 8'h28, 0);
        chk(rd, 32'hdead);
        $display("bus done");
        summarize();
    end
endmodule
